// *** bench/tb.sv ***
// Purpose: Self-checking bench for the port-1 tuning register bank.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: Expected bytes come from the register table, not the design.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
  import uhp_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, chirp_active = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_rvalid, reg_ready, charging_port_advert_enable, emphasis_enable;
  logic [3:0] otp_present = 4'h0;
  logic [7:0] otp_tx_adjust = 8'hA5, otp_pre_emphasis = 8'h11;
  logic [7:0] otp_rx_adjust = 8'h5A, otp_thresholds = 8'h22;
  logic [1:0] hs_termination_select, hs_transmit_slew_select, emphasis_width_select;
  logic [3:0] hs_transmit_swing_select, disconnect_level_select;
  logic [2:0] emphasis_level_select, receive_equalizer_select, squelch_level_select;
  logic [7:0] ofs [4] = '{8'h70, 8'h71, 8'h72, 8'h73};
  logic [7:0] dft [4] = '{8'h7C, 8'h3C, 8'h92, 8'h83};
  // Patterns keep reserved bits at their reset codes and emphasis level at 5h or less
  logic [7:0] pat [4][4] = '{'{8'hFF, 8'hBD, 8'h97, 8'hF7}, '{8'h00, 8'h00, 8'h90, 8'h00},
    '{8'hA6, 8'hA2, 8'h95, 8'hA5}, '{8'h59, 8'h1C, 8'h93, 8'h52}};
  int errors = 0, n_tests = 0;

  uhp_tuning_regs dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_ready(reg_ready), .otp_present(otp_present), .otp_tx_adjust(otp_tx_adjust),
    .otp_pre_emphasis(otp_pre_emphasis), .otp_rx_adjust(otp_rx_adjust),
    .otp_thresholds(otp_thresholds), .chirp_active(chirp_active),
    .hs_termination_select(hs_termination_select),
    .hs_transmit_slew_select(hs_transmit_slew_select),
    .hs_transmit_swing_select(hs_transmit_swing_select),
    .charging_port_advert_enable(charging_port_advert_enable),
    .emphasis_width_select(emphasis_width_select), .emphasis_enable(emphasis_enable),
    .emphasis_level_select(emphasis_level_select),
    .receive_equalizer_select(receive_equalizer_select),
    .disconnect_level_select(disconnect_level_select),
    .squelch_level_select(squelch_level_select));
  always #4 clk = ~clk;
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask
  task automatic do_reset(input logic [3:0] p);
    @(posedge clk);
    otp_present <= p;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 20 && reg_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(reg_ready, 1'b1)
  endtask
  // One edge after a register update the field outputs have settled
  task automatic chk_fields(input logic [7:0] e0, e1, e2, e3);
    logic [7:0] tx_now;
    @(posedge clk);
    #1;
    tx_now = {hs_termination_select, hs_transmit_slew_select, hs_transmit_swing_select};
    `CHK(tx_now, e0)
    `CHK({charging_port_advert_enable, emphasis_width_select}, {e1[7], e1[5:4]})
    `CHK(emphasis_enable, e1[3] & ~chirp_active)
    `CHK(emphasis_level_select, e1[2:0])
    `CHK(receive_equalizer_select, e2[2:0])
    `CHK({disconnect_level_select, squelch_level_select}, {e3[7:4], e3[2:0]})
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    do_reset(4'h0);
    chk_fields(dft[0], dft[1], dft[2], dft[3]);
    for (int i = 0; i < 4; i++) rd_chk(ofs[i], dft[i]);
  endtask
  // Registers without a factory value must ignore the OTP byte offered
  task automatic t_otp();
    do_reset(4'b0101);
    chk_fields(8'hA5, dft[1], 8'h5A, dft[3]);
    rd_chk(8'h70, 8'hA5);
    rd_chk(8'h71, dft[1]);
    rd_chk(8'h72, 8'h5A);
    rd_chk(8'h73, dft[3]);
  endtask
  task automatic t_write();
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 4; i++) wr(ofs[i], pat[p][i]);
      chk_fields(pat[p][0], pat[p][1], pat[p][2], pat[p][3]);
      for (int i = 0; i < 4; i++) rd_chk(ofs[i], pat[p][i]);
    end
  endtask
  task automatic t_unmapped();
    wr(8'h6F, 8'hFF);
    wr(8'h74, 8'hFF);
    rd_chk(8'h6F, 8'h00);
    rd_chk(8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(ofs[i], pat[3][i]);
  endtask
  task automatic t_chirp();
    wr(8'h71, 8'h08);
    @(posedge clk);
    chirp_active <= 1'b1;
    chk_fields(pat[3][0], 8'h08, pat[3][2], pat[3][3]);
    @(posedge clk);
    chirp_active <= 1'b0;
    chk_fields(pat[3][0], 8'h08, pat[3][2], pat[3][3]);
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  initial begin
    t_defaults();
    t_otp();
    t_write();
    t_unmapped();
    t_chirp();
    end_sim();
  end
endmodule

// *** bench/uhp_tuning_regs_monitor.sv ***
// Purpose: Port-level checks on the port-1 tuning register bank.
// Assumes: One clock; checks are off while resetn is low.
// Notes: A field shows a written byte two edges after the write is taken.
`timescale 1ns/1ps

module uhp_tuning_regs_monitor (
  input wire logic clk, // Core clock
  input wire logic resetn, // Reset, active low
  input wire logic [uhp_pkg::UHP_ADDR_W-1:0] reg_addr, // Offset
  input wire logic reg_wr, // Write strobe
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  input wire logic reg_rvalid, // Read valid
  input wire logic reg_ready, // Bank ready
  input wire logic chirp_active, // Chirp in progress
  input wire logic [uhp_pkg::UHP_TERM_W-1:0] hs_termination_select, // Termination
  input wire logic [uhp_pkg::UHP_SLEW_W-1:0] hs_transmit_slew_select, // Slew
  input wire logic [uhp_pkg::UHP_SWING_W-1:0] hs_transmit_swing_select, // Swing
  input wire logic charging_port_advert_enable, // Advert
  input wire logic [uhp_pkg::UHP_PE_WIDTH_W-1:0] emphasis_width_select, // Width
  input wire logic emphasis_enable, // Emphasis on
  input wire logic [uhp_pkg::UHP_PE_LEVEL_W-1:0] emphasis_level_select, // Level
  input wire logic [uhp_pkg::UHP_EQ_W-1:0] receive_equalizer_select, // Equalizer
  input wire logic [uhp_pkg::UHP_DISC_W-1:0] disconnect_level_select, // Disconnect
  input wire logic [uhp_pkg::UHP_SQ_W-1:0] squelch_level_select // Squelch
);
  import uhp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Accepted writes per register
  // ----------------------------------------------------------------
  logic wr70, wr71, wr72, wr73;
  assign wr70 = reg_wr && reg_ready && reg_addr == UHP_OFS_TX_ADJUST;
  assign wr71 = reg_wr && reg_ready && reg_addr == UHP_OFS_PRE_EMPHASIS;
  assign wr72 = reg_wr && reg_ready && reg_addr == UHP_OFS_RX_ADJUST;
  assign wr73 = reg_wr && reg_ready && reg_addr == UHP_OFS_THRESHOLDS;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_tx_fields: assert property (wr70 |=> ##1
    {hs_termination_select, hs_transmit_slew_select, hs_transmit_swing_select}
    == $past(reg_wdata, 2)) else $error("tx adjust fields wrong");
  a_cdp_bit: assert property (wr71 |=> ##1
    charging_port_advert_enable == $past(reg_wdata[7], 2)) else $error("advert bit wrong");
  a_pe_width: assert property (wr71 |=> ##1
    emphasis_width_select == $past(reg_wdata[5:4], 2)) else $error("width wrong");
  a_chirp_blocks: assert property (chirp_active |=> !emphasis_enable)
    else $error("emphasis on during chirp");
  a_pe_restore: assert property (wr71 ##1 !chirp_active |=>
    emphasis_enable == $past(reg_wdata[3], 2)) else $error("emphasis enable wrong");
  a_pe_level: assert property (wr71 |=> ##1
    emphasis_level_select == $past(reg_wdata[2:0], 2)) else $error("level wrong");
  a_eq_field: assert property (wr72 |=> ##1
    receive_equalizer_select == $past(reg_wdata[2:0], 2)) else $error("eq wrong");
  a_thr_fields: assert property (wr73 |=> ##1
    {disconnect_level_select, squelch_level_select} ==
    {$past(reg_wdata[7:4], 2), $past(reg_wdata[2:0], 2)}) else $error("thresholds wrong");
  a_disc_holds: assert property (reg_ready && !wr73 ##1 !wr73 |=>
    $stable(disconnect_level_select)) else $error("disconnect moved without write");
  a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd && reg_ready))
    else $error("read valid not one cycle after an accepted read");
  c_read: cover property (reg_rd && reg_ready ##1 reg_rvalid);
  c_write: cover property (wr71);
  c_chirp: cover property (chirp_active ##1 !chirp_active);
endmodule

bind uhp_tuning_regs uhp_tuning_regs_monitor u_mon (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .reg_ready(reg_ready), .chirp_active(chirp_active),
  .hs_termination_select(hs_termination_select),
  .hs_transmit_slew_select(hs_transmit_slew_select),
  .hs_transmit_swing_select(hs_transmit_swing_select),
  .charging_port_advert_enable(charging_port_advert_enable),
  .emphasis_width_select(emphasis_width_select), .emphasis_enable(emphasis_enable),
  .emphasis_level_select(emphasis_level_select),
  .receive_equalizer_select(receive_equalizer_select),
  .disconnect_level_select(disconnect_level_select),
  .squelch_level_select(squelch_level_select));

// *** logic/uhp_pkg.sv ***
// Purpose: Constants for the port-1 high-speed tuning register bank.
// Assumes: Byte-wide registers at byte offsets; one clock domain.
// Notes: Every offset, field position and reset value lives here once.
//
// Overview of operation
// - Reset loads hardware defaults; a present factory OTP value replaces the default.
// - 0x70 bits 7-6: termination select, four rising steps, default 1h.
// - 0x70 bits 5-4: transmit slew select, fastest to slowest, default 3h.
// - 0x70 bits 3-0: transmit swing select, sixteen rising steps, default Ch.
// - 0x71 bit 7: charging-port advertising enable, default 0.
// - 0x71 bits 5-4: emphasis width select, four growing widths, default 3h.
// - 0x71 bit 3: emphasis enable, default 1; forced off from one cycle after chirp_active rises.
// - 0x72 bits 2-0: receive equalizer select, default 2h; bits 7-4 reset 9h.
// - 0x73 bits 7-4: disconnect level select, sixteen rising steps, default 8h.
// - 0x73 bits 2-0: squelch level select, falling thresholds, default 3h; bit 3 resets 0.

package uhp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int UHP_ADDR_W = 8;
  localparam int UHP_DATA_W = 8;
  localparam int UHP_NUM_REGS = 4;

  localparam logic [7:0] UHP_OFS_TX_ADJUST = 8'h70;
  localparam logic [7:0] UHP_OFS_PRE_EMPHASIS = 8'h71;
  localparam logic [7:0] UHP_OFS_RX_ADJUST = 8'h72;
  localparam logic [7:0] UHP_OFS_THRESHOLDS = 8'h73;

  localparam logic [7:0] UHP_RST_TX_ADJUST = 8'h7C;
  localparam logic [7:0] UHP_RST_PRE_EMPHASIS = 8'h3C;
  localparam logic [7:0] UHP_RST_RX_ADJUST = 8'h92;
  localparam logic [7:0] UHP_RST_THRESHOLDS = 8'h83;

  localparam logic [7:0] UHP_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions (lsb and width)
  // ----------------------------------------------------------------
  localparam int UHP_TERM_LSB = 6;
  localparam int UHP_TERM_W = 2;
  localparam int UHP_SLEW_LSB = 4;
  localparam int UHP_SLEW_W = 2;
  localparam int UHP_SWING_LSB = 0;
  localparam int UHP_SWING_W = 4;

  localparam int UHP_CDP_BIT = 7;
  localparam int UHP_PE_WIDTH_LSB = 4;
  localparam int UHP_PE_WIDTH_W = 2;
  localparam int UHP_PE_EN_BIT = 3;
  localparam int UHP_PE_LEVEL_LSB = 0;
  localparam int UHP_PE_LEVEL_W = 3;

  localparam int UHP_EQ_LSB = 0;
  localparam int UHP_EQ_W = 3;

  localparam int UHP_DISC_LSB = 4;
  localparam int UHP_DISC_W = 4;
  localparam int UHP_SQ_LSB = 0;
  localparam int UHP_SQ_W = 3;

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    UHP_LOAD,
    UHP_RUN
  } uhp_state_type;

endpackage

// *** logic/uhp_tune_reg.sv ***
// Purpose: One byte-wide tuning register with default, OTP override and write.
// Assumes: Reset already synchronised by the parent.
// Notes: OTP load wins over a write in the same cycle.
`timescale 1ns/1ps

module uhp_tune_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic load_otp, // One-cycle strobe to take OTP
  input wire logic otp_present, // Factory value exists
  input wire logic [7:0] otp_value, // Factory value
  input wire logic wr_en, // Software write strobe
  input wire logic [7:0] wr_data, // Software write data
  output logic [7:0] value // Current contents
);
  import uhp_pkg::*;

  logic [7:0] value_q;
  logic [7:0] value_d;

  always_comb begin
    value_d = value_q;
    if (load_otp) begin
      if (otp_present) begin
        value_d = otp_value;
      end else begin
        value_d = RESET_VALUE;
      end
    end else if (wr_en) begin
      value_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule

// *** logic/uhp_tuning_regs.sv ***
// Purpose: Port-1 high-speed tuning register bank feeding the analog front end.
// Assumes: Register port and chirp flag come from logic on clk.
// Notes: Fields are exported as registered controls, one port each.
`timescale 1ns/1ps

module uhp_tuning_regs (
  input wire logic clk, // Core clock, 125 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [uhp_pkg::UHP_ADDR_W-1:0] reg_addr, // Register byte offset
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [uhp_pkg::UHP_DATA_W-1:0] reg_rdata, // Read data
  output logic reg_rvalid, // Read data valid, one cycle
  output logic reg_ready, // Bank accepts accesses
  input wire logic [uhp_pkg::UHP_NUM_REGS-1:0] otp_present, // Factory value per register
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] otp_tx_adjust, // Factory value 0x70
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] otp_pre_emphasis, // Factory value 0x71
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] otp_rx_adjust, // Factory value 0x72
  input wire logic [uhp_pkg::UHP_DATA_W-1:0] otp_thresholds, // Factory value 0x73
  input wire logic chirp_active, // Chirp J or K being driven
  output logic [uhp_pkg::UHP_TERM_W-1:0] hs_termination_select, // Termination code
  output logic [uhp_pkg::UHP_SLEW_W-1:0] hs_transmit_slew_select, // Slew code
  output logic [uhp_pkg::UHP_SWING_W-1:0] hs_transmit_swing_select, // Swing code
  output logic charging_port_advert_enable, // Charging-port advert on
  output logic [uhp_pkg::UHP_PE_WIDTH_W-1:0] emphasis_width_select, // Emphasis width
  output logic emphasis_enable, // Emphasis applied now
  output logic [uhp_pkg::UHP_PE_LEVEL_W-1:0] emphasis_level_select, // Emphasis level
  output logic [uhp_pkg::UHP_EQ_W-1:0] receive_equalizer_select, // Equalizer code
  output logic [uhp_pkg::UHP_DISC_W-1:0] disconnect_level_select, // Disconnect threshold
  output logic [uhp_pkg::UHP_SQ_W-1:0] squelch_level_select // Squelch threshold
);
  import uhp_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // Two stages so every flop of the bank leaves reset on the same edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Factory load sequence
  // ----------------------------------------------------------------
  // OTP is sampled by a clocked step after release, never by the async
  // reset itself, so the flops only ever reset to constants.
  uhp_state_type state_q;
  uhp_state_type state_d;
  logic load_otp;

  always_comb begin
    state_d = state_q;
    load_otp = 1'b0;
    case (state_q)
      UHP_LOAD: begin
        load_otp = 1'b1;
        state_d = UHP_RUN;
      end
      UHP_RUN: begin
        state_d = UHP_RUN;
      end
      default: begin
        state_d = UHP_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= UHP_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_tx;
  logic sel_pe;
  logic sel_rx;
  logic sel_th;
  logic access_ok;
  logic wr_tx;
  logic wr_pe;
  logic wr_rx;
  logic wr_th;
  logic rd_ok;

  always_comb begin
    sel_tx = (reg_addr == UHP_OFS_TX_ADJUST);
    sel_pe = (reg_addr == UHP_OFS_PRE_EMPHASIS);
    sel_rx = (reg_addr == UHP_OFS_RX_ADJUST);
    sel_th = (reg_addr == UHP_OFS_THRESHOLDS);
    access_ok = (state_q == UHP_RUN);
    // Accesses before the factory load has finished are dropped, so the
    // load can never silently overwrite a write that software believes landed.
    wr_tx = reg_wr && sel_tx && access_ok;
    wr_pe = reg_wr && sel_pe && access_ok;
    wr_rx = reg_wr && sel_rx && access_ok;
    wr_th = reg_wr && sel_th && access_ok;
    rd_ok = reg_rd && access_ok;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Reserved bits are stored as written; software keeps them intact.
  // Their reset codes ride in the defaults: 9h in 0x72 bits 7-4, 0 elsewhere
  logic [7:0] tx_adjust;
  logic [7:0] pre_emphasis;
  logic [7:0] rx_adjust;
  logic [7:0] thresholds;

  uhp_tune_reg #(
    .RESET_VALUE(UHP_RST_TX_ADJUST)
  ) u_tx_adjust (
    .clk(clk),
    .rst_n(rst_sync_q),
    .load_otp(load_otp),
    .otp_present(otp_present[0]),
    .otp_value(otp_tx_adjust),
    .wr_en(wr_tx),
    .wr_data(reg_wdata),
    .value(tx_adjust)
  );

  uhp_tune_reg #(
    .RESET_VALUE(UHP_RST_PRE_EMPHASIS)
  ) u_pre_emphasis (
    .clk(clk),
    .rst_n(rst_sync_q),
    .load_otp(load_otp),
    .otp_present(otp_present[1]),
    .otp_value(otp_pre_emphasis),
    .wr_en(wr_pe),
    .wr_data(reg_wdata),
    .value(pre_emphasis)
  );

  uhp_tune_reg #(
    .RESET_VALUE(UHP_RST_RX_ADJUST)
  ) u_rx_adjust (
    .clk(clk),
    .rst_n(rst_sync_q),
    .load_otp(load_otp),
    .otp_present(otp_present[2]),
    .otp_value(otp_rx_adjust),
    .wr_en(wr_rx),
    .wr_data(reg_wdata),
    .value(rx_adjust)
  );

  uhp_tune_reg #(
    .RESET_VALUE(UHP_RST_THRESHOLDS)
  ) u_thresholds (
    .clk(clk),
    .rst_n(rst_sync_q),
    .load_otp(load_otp),
    .otp_present(otp_present[3]),
    .otp_value(otp_thresholds),
    .wr_en(wr_th),
    .wr_data(reg_wdata),
    .value(thresholds)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic ready_q;
  logic ready_d;

  always_comb begin
    rvalid_d = rd_ok;
    ready_d = (state_d == UHP_RUN);
    rdata_d = rdata_q;
    if (rd_ok) begin
      if (sel_tx) begin
        rdata_d = tx_adjust;
      end else if (sel_pe) begin
        rdata_d = pre_emphasis;
      end else if (sel_rx) begin
        rdata_d = rx_adjust;
      end else if (sel_th) begin
        rdata_d = thresholds;
      end else begin
        rdata_d = UHP_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      ready_q <= ready_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign reg_ready = ready_q;

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  // Controls are re-registered so the analog side sees glitch-free
  // flop outputs; they trail the register contents by one cycle.
  // Limitation: emphasis drops one cycle after chirp_active rises, so the
  // chirp source must raise it one cycle before the first chirp symbol.
  logic [UHP_TERM_W-1:0] term_q;
  logic [UHP_TERM_W-1:0] term_d;
  logic [UHP_SLEW_W-1:0] slew_q;
  logic [UHP_SLEW_W-1:0] slew_d;
  logic [UHP_SWING_W-1:0] swing_q;
  logic [UHP_SWING_W-1:0] swing_d;
  logic cdp_q;
  logic cdp_d;
  logic [UHP_PE_WIDTH_W-1:0] pe_width_q;
  logic [UHP_PE_WIDTH_W-1:0] pe_width_d;
  logic pe_en_q;
  logic pe_en_d;
  logic [UHP_PE_LEVEL_W-1:0] pe_level_q;
  logic [UHP_PE_LEVEL_W-1:0] pe_level_d;
  logic [UHP_EQ_W-1:0] eq_q;
  logic [UHP_EQ_W-1:0] eq_d;
  logic [UHP_DISC_W-1:0] disc_q;
  logic [UHP_DISC_W-1:0] disc_d;
  logic [UHP_SQ_W-1:0] sq_q;
  logic [UHP_SQ_W-1:0] sq_d;

  always_comb begin
    term_d = tx_adjust[UHP_TERM_LSB +: UHP_TERM_W];
    slew_d = tx_adjust[UHP_SLEW_LSB +: UHP_SLEW_W];
    swing_d = tx_adjust[UHP_SWING_LSB +: UHP_SWING_W];
    cdp_d = pre_emphasis[UHP_CDP_BIT];
    pe_width_d = pre_emphasis[UHP_PE_WIDTH_LSB +: UHP_PE_WIDTH_W];
    // Chirp must stay clean regardless of the software setting
    pe_en_d = pre_emphasis[UHP_PE_EN_BIT] && !chirp_active;
    // Codes 6h and 7h pass through unchanged; software avoids them
    pe_level_d = pre_emphasis[UHP_PE_LEVEL_LSB +: UHP_PE_LEVEL_W];
    eq_d = rx_adjust[UHP_EQ_LSB +: UHP_EQ_W];
    disc_d = thresholds[UHP_DISC_LSB +: UHP_DISC_W];
    sq_d = thresholds[UHP_SQ_LSB +: UHP_SQ_W];
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      term_q <= UHP_RST_TX_ADJUST[UHP_TERM_LSB +: UHP_TERM_W];
      slew_q <= UHP_RST_TX_ADJUST[UHP_SLEW_LSB +: UHP_SLEW_W];
      swing_q <= UHP_RST_TX_ADJUST[UHP_SWING_LSB +: UHP_SWING_W];
      cdp_q <= UHP_RST_PRE_EMPHASIS[UHP_CDP_BIT];
      pe_width_q <= UHP_RST_PRE_EMPHASIS[UHP_PE_WIDTH_LSB +: UHP_PE_WIDTH_W];
      // Emphasis stays off until the first edge after release, which still uses the default setting
      pe_en_q <= 1'b0;
      pe_level_q <= UHP_RST_PRE_EMPHASIS[UHP_PE_LEVEL_LSB +: UHP_PE_LEVEL_W];
      eq_q <= UHP_RST_RX_ADJUST[UHP_EQ_LSB +: UHP_EQ_W];
      disc_q <= UHP_RST_THRESHOLDS[UHP_DISC_LSB +: UHP_DISC_W];
      sq_q <= UHP_RST_THRESHOLDS[UHP_SQ_LSB +: UHP_SQ_W];
    end else begin
      term_q <= term_d;
      slew_q <= slew_d;
      swing_q <= swing_d;
      cdp_q <= cdp_d;
      pe_width_q <= pe_width_d;
      pe_en_q <= pe_en_d;
      pe_level_q <= pe_level_d;
      eq_q <= eq_d;
      disc_q <= disc_d;
      sq_q <= sq_d;
    end
  end

  assign hs_termination_select = term_q;
  assign hs_transmit_slew_select = slew_q;
  assign hs_transmit_swing_select = swing_q;
  assign charging_port_advert_enable = cdp_q;
  assign emphasis_width_select = pe_width_q;
  assign emphasis_enable = pe_en_q;
  assign emphasis_level_select = pe_level_q;
  assign receive_equalizer_select = eq_q;
  assign disconnect_level_select = disc_q;
  assign squelch_level_select = sq_q;

endmodule
